// ---- design/lsd_pkg.sv ----
package lsd_pkg;
   // ----------------------------------------------------------------
   // channel layout
   // ----------------------------------------------------------------
   localparam int NUM_CH = 4;
   localparam logic [3:0] REG_CH_MASK = 4'hC;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int RESET_DELAY_US = 100;
   localparam int RESET_DELAY_CYC = RESET_DELAY_US * 1000 / CLK_PERIOD_NS;
   localparam int CLK_LOSS_NS = 10000;
   localparam int CLK_LOSS_CYC = CLK_LOSS_NS / CLK_PERIOD_NS;
endpackage : lsd_pkg

// ---- design/lsd_low_timer.sv ----
`timescale 1ns/100ps
module lsd_low_timer #(
   parameter int DELAY_CYC = 10000
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // level watched
   input wire logic low_in,
   // low held longer than the delay
   output logic long_low
);
   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt;
   logic long_ff;
   logic nxt_long;

   always_comb
   begin
      nxt_cnt = 32'h0;
      nxt_long = 1'b0;
      if (low_in)
      begin
         // short low pulses count as pwm and never reach the end
         nxt_long = (cnt_ff >= 32'(DELAY_CYC - 1));
         nxt_cnt = nxt_long ? cnt_ff : cnt_ff + 32'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_ff <= 32'h0;
         long_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         long_ff <= nxt_long;
      end
   end

   assign long_low = long_ff;
endmodule : lsd_low_timer

// ---- design/lsd_switch_diag.sv ----
`timescale 1ns/100ps
module lsd_switch_diag #(
   parameter int RESET_DELAY = lsd_pkg::RESET_DELAY_CYC,
   parameter int LOSS_DELAY = lsd_pkg::CLK_LOSS_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // controller pins
   input wire logic shared_output_enable,
   input wire logic [3:0] ctrl_in,
   input wire logic test_pin,
   input wire logic ext_clk,
   input wire logic logic_powerup,
   // analog detector flags, per channel, plus one shared drift flag
   input wire logic [3:0] open_load_det,
   input wire logic [3:0] overload_det,
   input wire logic [3:0] overtemp_det,
   input wire logic [3:0] recirc_det,
   input wire logic drift_fail_det,
   // power stage and status pins
   output logic [3:0] power_on,
   output logic [3:0] channel_status_output
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [12:0] s1_ff, s2_ff;
   logic [12:0] raw;
   assign raw = {drift_fail_det, logic_powerup, ext_clk, test_pin,
                 shared_output_enable, ctrl_in, open_load_det};
   logic [11:0] f1_ff, f2_ff;
   logic [11:0] fraw;
   assign fraw = {overload_det, overtemp_det, recirc_det};
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s1_ff <= 13'h0;
         s2_ff <= 13'h0;
         f1_ff <= 12'h0;
         f2_ff <= 12'h0;
      end
      else
      begin
         s1_ff <= raw;
         s2_ff <= s1_ff;
         f1_ff <= fraw;
         f2_ff <= f1_ff;
      end
   end
   logic en_sync, tst, eclk, pwrup, drift;
   logic [3:0] inp, ol, ovl, ot, rc;
   assign ol = s2_ff[3:0];
   assign inp = s2_ff[7:4];
   assign en_sync = s2_ff[8];
   assign tst = s2_ff[9];
   assign eclk = s2_ff[10];
   assign pwrup = s2_ff[11];
   assign drift = s2_ff[12];
   assign ovl = f2_ff[11:8];
   assign ot = f2_ff[7:4];
   assign rc = f2_ff[3:0];

   // ----------------------------------------------------------------
   // clock loss watchdog
   // ----------------------------------------------------------------
   logic eclk_d_ff, nxt_eclk_d;
   logic [31:0] loss_cnt_ff, nxt_loss_cnt;
   logic loss_ff, nxt_loss;
   always_comb
   begin
      nxt_eclk_d = eclk;
      nxt_loss_cnt = loss_cnt_ff;
      nxt_loss = loss_ff;
      if (eclk != eclk_d_ff)
      begin
         nxt_loss_cnt = 32'h0;
         nxt_loss = 1'b0;
      end
      else if (loss_cnt_ff >= 32'(LOSS_DELAY - 1))
         nxt_loss = 1'b1;
      else
         nxt_loss_cnt = loss_cnt_ff + 32'h1;
   end
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         eclk_d_ff <= 1'b0;
         loss_cnt_ff <= 32'h0;
         loss_ff <= 1'b0;
      end
      else
      begin
         eclk_d_ff <= nxt_eclk_d;
         loss_cnt_ff <= nxt_loss_cnt;
         loss_ff <= nxt_loss;
      end
   end

   // ----------------------------------------------------------------
   // per-channel fault latches
   // ----------------------------------------------------------------
   logic [3:0] long_low;
   logic [3:0] loss_ch;
   logic [3:0] latch_ff, nxt_latch;
   logic [3:0] cmd_on;
   logic [3:0] pwr_ff, nxt_pwr;
   logic [3:0] status_ff, nxt_status;
   genvar g;
   generate
      for (g = 0; g < lsd_pkg::NUM_CH; g++)
      begin : g_ch
         lsd_low_timer #(
            .DELAY_CYC(RESET_DELAY)
         ) u_timer (
            .sys_clk(sys_clk),
            .reset_n(reset_n),
            .low_in(~(en_sync & inp[g])),
            .long_low(long_low[g])
         );
      end
   endgenerate

   // clock loss during logic power-up reaches only the regulated pair
   assign loss_ch = {4{loss_ff}} & (pwrup ? lsd_pkg::REG_CH_MASK : 4'hF);

   logic drift_mode;
   assign drift_mode = tst & en_sync;
   assign cmd_on = {4{en_sync}} & inp;

   always_comb
   begin
      nxt_latch = latch_ff;
      nxt_pwr = 4'h0;
      nxt_status = 4'h0;
      for (int i = 0; i < lsd_pkg::NUM_CH; i++)
      begin
         // a fault in the release cycle wins, so no fault event is lost
         if (cmd_on[i] & (ovl[i] | ot[i] |
             (rc[i] & lsd_pkg::REG_CH_MASK[i])))
            nxt_latch[i] = 1'b1;
         // enable or input held low for RESET_DELAY cycles releases the latch
         else if (long_low[i])
            nxt_latch[i] = 1'b0;
         if (drift_mode && lsd_pkg::REG_CH_MASK[i] && inp[i])
         begin
            nxt_pwr[i] = ~loss_ch[i];
            nxt_status[i] = ~drift;
         end
         else if (loss_ch[i])
         begin
            nxt_pwr[i] = 1'b0;
            nxt_status[i] = ~cmd_on[i];
         end
         else if (nxt_latch[i] | latch_ff[i])
         begin
            nxt_pwr[i] = 1'b0;
            nxt_status[i] = 1'b0;
         end
         else if (ol[i])
         begin
            nxt_pwr[i] = cmd_on[i];
            nxt_status[i] = en_sync & ~inp[i];
         end
         else
         begin
            nxt_pwr[i] = cmd_on[i];
            nxt_status[i] = cmd_on[i];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         latch_ff <= 4'h0;
         pwr_ff <= 4'h0;
         status_ff <= 4'h0;
      end
      else
      begin
         latch_ff <= nxt_latch;
         pwr_ff <= nxt_pwr;
         status_ff <= nxt_status;
      end
   end

   assign power_on = pwr_ff;
   assign channel_status_output = status_ff;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_latch_forces_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (latch_ff != 4'h0) |=> ((power_on & $past(latch_ff)) == 4'h0 || $past(drift_mode)))
      else $error("latched channel still powered");
   a_loss_all_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (loss_ff && !pwrup && !tst) |=> (power_on == 4'h0))
      else $error("clock loss left an output on");
   a_loss_status: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (loss_ff && !pwrup && !tst) |=> (channel_status_output == ~$past(cmd_on)))
      else $error("clock loss status wrong");
   a_normal_follow: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (!loss_ff && !tst && ol == 4'h0 && latch_ff == 4'h0 && ovl == 4'h0 && ot == 4'h0
       && rc == 4'h0) |=> (channel_status_output == $past(cmd_on)))
      else $error("status does not follow command");
   a_powerup_mask: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (loss_ff && pwrup && !tst) |=> (power_on[3:2] == 2'b00))
      else $error("regulated channels on during power-up clock loss");
   a_latch_holds: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (latch_ff[0] && !long_low[0]) |=> latch_ff[0])
      else $error("latch cleared without long low");
   a_latch_sets: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (cmd_on[1] && ot[1] && !long_low[1]) |=> latch_ff[1])
      else $error("overtemperature not latched");
   a_drift_report: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (drift_mode && inp[3] && !loss_ch[3]) |=> (power_on[3] && channel_status_output[3]
       == !$past(drift)))
      else $error("drift test output wrong");
endmodule : lsd_switch_diag

// ---- sim/lsd_ctrl_model.sv ----
`timescale 1ns/100ps
// controller side clock source; a stopped clock stands still, as a lost one would
module lsd_ctrl_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // run request
   input wire logic clk_run,
   // clock pin
   output logic ext_clk
);
   logic ext_ff;
   logic nxt_ext;
   always_comb
   begin
      nxt_ext = clk_run ? !ext_ff : ext_ff;
   end
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         ext_ff <= 1'h0;
      else
         ext_ff <= nxt_ext;
   end
   assign ext_clk = ext_ff;
endmodule : lsd_ctrl_model

// ---- sim/lsd_switch_diag_tb.sv ----
`timescale 1ns/100ps
module lsd_switch_diag_tb;
   logic sys_clk = 1'h0;
   logic reset_n = 1'h0;
   logic out_en = 1'h0;
   logic [3:0] ctrl = 4'h0;
   logic test_pin = 1'h0;
   logic clk_run = 1'h1;
   logic pwr_up = 1'h0;
   logic [3:0] ol = 4'h0;
   logic [3:0] ovl = 4'h0;
   logic [3:0] ot = 4'h0;
   logic [3:0] rc = 4'h0;
   logic drift = 1'h0;
   logic ext_clk;
   logic [3:0] power_on;
   logic [3:0] channel_status_output;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #5 sys_clk = !sys_clk;
   lsd_ctrl_model lsd_ctrl_model_inst (.sys_clk(sys_clk), .reset_n(reset_n),
      .clk_run(clk_run), .ext_clk(ext_clk));
   lsd_switch_diag #(.RESET_DELAY(20), .LOSS_DELAY(16)) lsd_switch_diag_inst (
      .sys_clk(sys_clk), .reset_n(reset_n), .shared_output_enable(out_en),
      .ctrl_in(ctrl), .test_pin(test_pin), .ext_clk(ext_clk),
      .logic_powerup(pwr_up), .open_load_det(ol), .overload_det(ovl),
      .overtemp_det(ot), .recirc_det(rc), .drift_fail_det(drift),
      .power_on(power_on), .channel_status_output(channel_status_output));
   // ----
   // shared tasks
   // ----
   task conclude;
      if (error_cnt == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude
   task drv(input logic e, input logic [3:0] i);
      @(posedge sys_clk);
      out_en <= e;
      ctrl <= i;
   endtask : drv
   task wait_cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wait_cyc
   task expect_status(input logic [3:0] s);
      wait_cyc(6);
      cmp_count++;
      if (channel_status_output !== s)
      begin
         error_cnt++;
         $display("MISMATCH status t=%0t got %h exp %h", $time, channel_status_output, s);
      end
   endtask : expect_status
   task expect_out(input logic [3:0] p, input logic [3:0] s);
      expect_status(s);
      cmp_count++;
      if (power_on !== p)
      begin
         error_cnt++;
         $display("MISMATCH power t=%0t got %h exp %h", $time, power_on, p);
      end
   endtask : expect_out
   // ----
   // scenarios
   // ----
   task t_normal;
      drv(1'h1, 4'h5);
      expect_out(4'h5, 4'h5);
      drv(1'h0, 4'hF);
      expect_out(4'h0, 4'h0);
   endtask : t_normal
   task t_open;
      ol <= 4'hF;
      drv(1'h1, 4'h0);
      expect_status(4'hF);
      drv(1'h1, 4'hF);
      expect_status(4'h0);
      ol <= 4'h0;
   endtask : t_open
   task t_latch;
      drv(1'h1, 4'hF);
      ovl <= 4'h1;
      expect_out(4'hE, 4'hE);
      ovl <= 4'h0;
      expect_out(4'hE, 4'hE);
      drv(1'h1, 4'h0);
      wait_cyc(5);
      drv(1'h1, 4'hF);
      expect_out(4'hE, 4'hE);
      drv(1'h1, 4'h0);
      wait_cyc(30);
      drv(1'h1, 4'hF);
      expect_out(4'hF, 4'hF);
      ot <= 4'h2;
      expect_out(4'hD, 4'hD);
      ot <= 4'h0;
      drv(1'h0, 4'hF);
      wait_cyc(30);
      drv(1'h1, 4'hF);
      expect_out(4'hF, 4'hF);
      rc <= 4'hC;
      expect_out(4'h3, 4'h3);
      rc <= 4'h0;
      drv(1'h1, 4'h0);
      wait_cyc(30);
      drv(1'h1, 4'hF);
      expect_out(4'hF, 4'hF);
   endtask : t_latch
   task t_clk_loss;
      clk_run <= 1'h0;
      wait_cyc(24);
      expect_out(4'h0, 4'h0);
      drv(1'h1, 4'h0);
      expect_status(4'hF);
      drv(1'h0, 4'hF);
      expect_status(4'hF);
      clk_run <= 1'h1;
      drv(1'h0, 4'h0);
      wait_cyc(30);
      expect_out(4'h0, 4'h0);
      pwr_up <= 1'h1;
      clk_run <= 1'h0;
      drv(1'h1, 4'h0);
      wait_cyc(24);
      expect_out(4'h0, 4'hC);
      clk_run <= 1'h1;
      pwr_up <= 1'h0;
      drv(1'h0, 4'h0);
      wait_cyc(30);
   endtask : t_clk_loss
   task t_drift;
      test_pin <= 1'h1;
      drv(1'h1, 4'hC);
      expect_out(4'hC, 4'hC);
      drift <= 1'h1;
      expect_out(4'hC, 4'h0);
      drift <= 1'h0;
      test_pin <= 1'h0;
   endtask : t_drift
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         error_cnt++;
         conclude();
      end
   end
   initial
   begin
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'h1;
      t_normal();
      t_open();
      t_latch();
      t_clk_loss();
      t_drift();
      conclude();
   end
endmodule : lsd_switch_diag_tb
